// ---- pkg/sflm_pkg.sv ----
// constants and types for the serial flash lane mode switch
package sflm_pkg;
  // command codes
  localparam logic [7:0] CMD_ENTER_FOUR_LANE = 8'h38;
  localparam logic [7:0] CMD_EXIT_FOUR_LANE = 8'hff;
  localparam logic [7:0] CMD_READ_PARAM = 8'h5a;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_DATA = 8'h03;
  // apb register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  // status register layout and delivered value
  localparam int QUAD_PERMIT_POS = 9;
  localparam int DRIVE_LOW_POS = 21;
  localparam logic [23:0] STATUS_RESET = 24'h200000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // flags register bit positions
  localparam int FLAG_FOUR_LANE = 0;
  localparam int FLAG_WRITE_PERMIT = 1;
  localparam int FLAG_SUSPEND = 2;
  localparam int FLAG_READY = 3;
  localparam int WRAP_POS = 4;
  // power-up wait, in microseconds, and clock rate
  localparam int SUPPLY_WAIT_US = 1800;
  localparam int CLOCK_MHZ = 250;
  localparam int SUPPLY_WAIT_CYCLES = SUPPLY_WAIT_US * CLOCK_MHZ;
  // parameter table signature byte, arbitrary value
  localparam logic [7:0] PARAM_SIGNATURE = 8'h5a;
  typedef enum logic [1:0] {SFLM_IDLE, SFLM_CMD, SFLM_ADDR, SFLM_DATA} sflm_state_t;
endpackage

// ---- src/sflm_lane_switch.sv ----
// command front end: lane mode switching, status, parameter table reads
`timescale 1ns/1ps
module sflm_lane_switch
  import sflm_pkg::*;
#(
  parameter int WAIT_CYCLES = SUPPLY_WAIT_CYCLES,
  parameter int TABLE_DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic four_lane_mode,
  output logic ready,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  if (TABLE_DEPTH < 2 || TABLE_DEPTH > 256 || WAIT_CYCLES < 1) begin : g_bad_param
    $error("table depth or wait cycles out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage is read only by the second
  logic [5:0] sync1_r, sync2_r, prev_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r <= 6'h01;
      sync2_r <= 6'h01;
      prev_r <= 6'h01;
    end else begin
      sync1_r <= {io_in, sclk, select_n};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  wire sel_n_s = sync2_r[0];
  wire sck_rise = sync2_r[1] & ~prev_r[1];
  wire sck_fall = ~sync2_r[1] & prev_r[1];
  wire deselect = sel_n_s & ~prev_r[0];
  wire [3:0] io_s = sync2_r[5:2];

  ////////////////////////////////////////////////////////////////////
  // parameter table: constant pattern, signature byte first
  logic [7:0] table_mem [TABLE_DEPTH];
  for (genvar g = 0; g < TABLE_DEPTH; g++) begin : g_table
    assign table_mem[g] = (g == 0) ? PARAM_SIGNATURE : 8'(g);
  end

  ////////////////////////////////////////////////////////////////////
  // serial state
  sflm_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt, cmd_r, cmd_nxt, out_r, out_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic four_lane_r, four_lane_nxt, code_done_r, code_done_nxt;
  logic [23:0] status_r, status_nxt;
  logic write_permit_r, write_permit_nxt, suspend_r, suspend_nxt;
  logic [1:0] wrap_r, wrap_nxt;
  logic [3:0] oe_r, oe_nxt, dout_r, dout_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic ready_r, ready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;

  // one serial step: four bits in four-lane mode, one otherwise
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
                                          input logic quad);
    return quad ? {s[3:0], d} : {s[6:0], d[0]};
  endfunction

  wire [4:0] step = four_lane_r ? 5'd4 : 5'd1;
  wire [7:0] shifted = shift_in(shift_r, io_s, four_lane_r);
  wire apb_write = psel & penable & pwrite & pready_r; // lands on the edge that sees pready

  // command decoder and mode switch
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    cmd_nxt = cmd_r;
    bits_nxt = bits_r;
    addr_nxt = addr_r;
    out_nxt = out_r;
    four_lane_nxt = four_lane_r;
    code_done_nxt = code_done_r;
    status_nxt = status_r;
    write_permit_nxt = write_permit_r; // kept across switches
    suspend_nxt = suspend_r;
    wrap_nxt = wrap_r;
    oe_nxt = oe_r;
    dout_nxt = dout_r;
    wait_nxt = (wait_r != 0) ? wait_r - 32'd1 : wait_r;
    ready_nxt = (wait_r == 0);
    if (sel_n_s) begin
      // mode change only at deselect after a whole code
      if (deselect && code_done_r) begin
        if (cmd_r == CMD_ENTER_FOUR_LANE && !four_lane_r &&
            status_r[QUAD_PERMIT_POS]) begin
          four_lane_nxt = 1'b1;
        end else if (cmd_r == CMD_EXIT_FOUR_LANE && four_lane_r) begin
          four_lane_nxt = 1'b0;
        end else if (cmd_r == CMD_WRITE_ENABLE) begin
          write_permit_nxt = 1'b1;
        end else if (cmd_r == CMD_WRITE_DISABLE) begin
          write_permit_nxt = 1'b0;
        end
        // 38H without permit falls through unchanged
      end
      state_nxt = SFLM_IDLE;
      bits_nxt = 5'd0;
      code_done_nxt = 1'b0;
      oe_nxt = 4'h0;
    end else if (ready_r) begin
      if (state_r == SFLM_IDLE) begin
        state_nxt = SFLM_CMD;
      end
      case (state_r)
        SFLM_IDLE, SFLM_CMD: begin
          if (sck_rise) begin
            shift_nxt = shifted;
            bits_nxt = bits_r + step;
            if (bits_r + step == 5'd8) begin
              cmd_nxt = shifted;
              code_done_nxt = 1'b1;
              bits_nxt = 5'd0;
              if (shifted == CMD_READ_PARAM || shifted == CMD_READ_DATA) begin
                state_nxt = SFLM_ADDR;
              end else if (shifted == CMD_READ_STATUS) begin
                state_nxt = SFLM_DATA;
                out_nxt = status_r[7:0];
              end else begin
                state_nxt = SFLM_DATA;
                out_nxt = 8'h00;
              end
            end
          end
        end
        SFLM_ADDR: begin
          if (sck_rise) begin
            shift_nxt = shifted;
            bits_nxt = bits_r + step;
            if (bits_r + step == 5'd8) begin
              addr_nxt = shifted;
              bits_nxt = 5'd0;
              state_nxt = SFLM_DATA;
              // parameter table read array reads erased
              out_nxt = (cmd_r == CMD_READ_PARAM) ?
                        table_mem[shifted % TABLE_DEPTH] : ERASED_BYTE;
            end
          end
        end
        SFLM_DATA: begin
          if (sck_fall) begin
            oe_nxt = four_lane_r ? 4'hf : 4'h2;
            dout_nxt = four_lane_r ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
            out_nxt = four_lane_r ? {out_r[3:0], 4'h0} : {out_r[6:0], 1'b0};
            bits_nxt = bits_r + step;
            if (bits_r + step == 5'd8) begin
              bits_nxt = 5'd0;
              addr_nxt = addr_r + 8'h01;
              out_nxt = (cmd_r == CMD_READ_PARAM) ?
                        table_mem[(addr_r + 8'h01) % TABLE_DEPTH] :
                        (cmd_r == CMD_READ_DATA) ? ERASED_BYTE : status_r[7:0];
            end
          end
        end
        default: state_nxt = SFLM_IDLE;
      endcase
    end
    if (apb_write && paddr == REG_STATUS) begin
      status_nxt = pwdata[23:0];
    end else if (apb_write && paddr == REG_CONTROL) begin
      suspend_nxt = pwdata[FLAG_SUSPEND];
      wrap_nxt = pwdata[WRAP_POS+1:WRAP_POS];
    end
  end

  // apb slave: one wait state, registered answer
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0;
    if (psel && penable && !pready_r) begin
      if (paddr == REG_CONTROL) begin
        prdata_nxt = {26'h0, wrap_r, 1'b0, suspend_r, 2'b00};
      end else if (paddr == REG_STATUS) begin
        prdata_nxt = {8'h00, status_r};
      end else if (paddr == REG_FLAGS) begin
        prdata_nxt = {26'h0, wrap_r, ready_r, suspend_r, write_permit_r, four_lane_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= SFLM_IDLE;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      bits_r <= 5'd0;
      addr_r <= 8'h00;
      out_r <= 8'h00;
      four_lane_r <= 1'b0;
      code_done_r <= 1'b0;
      status_r <= STATUS_RESET; // delivered status value
      write_permit_r <= 1'b0;
      suspend_r <= 1'b0;
      wrap_r <= 2'b00;
      oe_r <= 4'h0;
      dout_r <= 4'h0;
      wait_r <= 32'(WAIT_CYCLES); // no command until the supply wait ends
      ready_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      cmd_r <= cmd_nxt;
      bits_r <= bits_nxt;
      addr_r <= addr_nxt;
      out_r <= out_nxt;
      four_lane_r <= four_lane_nxt;
      code_done_r <= code_done_nxt;
      status_r <= status_nxt;
      write_permit_r <= write_permit_nxt;
      suspend_r <= suspend_nxt;
      wrap_r <= wrap_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
      wait_r <= wait_nxt;
      ready_r <= ready_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign io_out = dout_r;
  assign io_oe = oe_r;
  assign four_lane_mode = four_lane_r;
  assign ready = ready_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_enter_permit: assert property (@(posedge clock) disable iff (reset)
    ($rose(four_lane_r) |-> $past(status_r[QUAD_PERMIT_POS]) && $past(cmd_r) == 8'h38))
    else $error("four-lane entry without permit");
  a_enter_refused: assert property (@(posedge clock) disable iff (reset)
    (deselect && code_done_r && cmd_r == 8'h38 && !status_r[QUAD_PERMIT_POS] && !four_lane_r
     |=> !four_lane_r)) else $error("entry taken without permit");
  a_exit_cmd: assert property (@(posedge clock) disable iff (reset)
    ($fell(four_lane_r) |-> $past(cmd_r) == 8'hff && $past(deselect)))
    else $error("exit without ffh");
  a_keep_enter: assert property (@(posedge clock) disable iff (reset)
    ($rose(four_lane_r) |-> $stable(write_permit_r) && $stable(suspend_r) && $stable(wrap_r)))
    else $error("state changed on entry");
  a_keep_exit: assert property (@(posedge clock) disable iff (reset)
    ($fell(four_lane_r) |-> $stable(write_permit_r) && $stable(suspend_r) && $stable(wrap_r)))
    else $error("state changed on exit");
  a_table_sig: assert property (@(posedge clock) disable iff (reset)
    (state_r == SFLM_ADDR && state_nxt == SFLM_DATA && cmd_r == 8'h5a && shifted == 8'h00
     |=> out_r == PARAM_SIGNATURE)) else $error("bad table byte");
  a_erased_read: assert property (@(posedge clock) disable iff (reset)
    (state_r == SFLM_ADDR && state_nxt == SFLM_DATA && cmd_r == 8'h03 |=> out_r == 8'hff))
    else $error("array not erased");
  a_status_init: assert property (@(posedge clock)
    ($fell(reset) |-> status_r == 24'h200000)) else $error("bad delivered status");
  a_mode_deselect: assert property (@(posedge clock) disable iff (reset)
    ($changed(four_lane_r) |-> $past(sel_n_s) && $past(code_done_r)))
    else $error("mode changed while selected");
endmodule

// ---- sim/sflm_host_model.sv ----
// host flash controller model: drives select, link clock and data lanes
`timescale 1ns/1ps
module sflm_host (
  input wire logic clock,
  output logic select_n,
  output logic sclk,
  output logic [3:0] lanes_out,
  input wire logic [3:0] lanes_in
);
  // link clock stands low between frames
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    lanes_out = 4'h0;
  end
  // half of the 80 ns link period at the 4 ns block clock
  task automatic half();
    repeat (10) @(posedge clock);
  endtask
  // n rises, msb first; lane 1 sampled just before each rise
  task automatic shift(input logic [7:0] v, input int n, input logic quad,
                       inout logic [7:0] rx);
    for (int i = 0; i < n; i++) begin
      lanes_out <= quad ? v[7-4*i -: 4] : {3'h0, v[7-i]};
      half();
      rx = {rx[6:0], lanes_in[1]};
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
  // one framed command; extra 1 reads a byte, extra 2 sends an address first
  task automatic frame(input logic [7:0] code, input int n, input logic quad,
                       input int extra, input logic [7:0] addr, output logic [7:0] rx);
    rx = 8'h00;
    select_n <= 1'b0;
    half();
    shift(code, n, quad, rx);
    if (extra > 1) shift(addr, 8, 1'b0, rx);
    if (extra > 0) shift(8'h00, 8, 1'b0, rx);
    half();
    select_n <= 1'b1;
    // released lanes flip so a stale bit never looks driven
    lanes_out <= ~lanes_out;
    half();
  endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the lane mode switch
`timescale 1ns/1ps
module tb;
  import sflm_pkg::*;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, four_lane_mode, ready;
  logic select_n, sclk, err;
  logic [3:0] io_in, io_out, io_oe, lanes;
  logic [7:0] paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  int err_count = 0;
  int check_count = 0;
  int n;
  // undriven lanes float, so a lane the block never drives cannot match
  assign lanes = (io_out & io_oe) | (4'bxxxx & ~io_oe);
  sflm_lane_switch #(.WAIT_CYCLES(10), .TABLE_DEPTH(16)) sflm_lane_switch_inst (
    .clock(clock), .reset(reset), .select_n(select_n), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .four_lane_mode(four_lane_mode), .ready(ready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  sflm_host sflm_host_inst (.clock(clock), .select_n(select_n), .sclk(sclk),
    .lanes_out(io_in), .lanes_in(lanes));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge; bounded wait on pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0, 32'h1);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // nothing is sent on the link until the power-up wait is over
    chk(32'(ready), 32'h0);
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 40), 32'h1);
    if (n >= 40) final_report();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h00200000);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 8'h0c, 32'h0);
    chk(32'(err), 32'h1);
    sflm_host_inst.frame(CMD_READ_STATUS, 8, 1'b0, 1, 8'h00, rx);
    chk(32'(rx), 32'h00);
    sflm_host_inst.frame(CMD_READ_DATA, 8, 1'b0, 2, 8'h10, rx);
    chk(32'(rx), 32'hff);
    sflm_host_inst.frame(CMD_READ_PARAM, 8, 1'b0, 2, 8'h00, rx);
    chk(32'(rx), 32'h5a);
    sflm_host_inst.frame(CMD_READ_PARAM, 8, 1'b0, 2, 8'h0f, rx);
    chk(32'(rx), 32'h0f);
    $display("test 1 done");
    // switch refused while the permit bit is clear
    sflm_host_inst.frame(CMD_ENTER_FOUR_LANE, 8, 1'b0, 0, 8'h00, rx);
    chk(32'(four_lane_mode), 32'h0);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h8);
    $display("test 2 done");
    // suspend, wrap and write permit set, then permit bit before entry
    apb(1'b1, REG_CONTROL, 32'h34);
    sflm_host_inst.frame(CMD_WRITE_ENABLE, 8, 1'b0, 0, 8'h00, rx);
    apb(1'b1, REG_STATUS, 32'h00200200);
    sflm_host_inst.frame(CMD_ENTER_FOUR_LANE, 4, 1'b0, 0, 8'h00, rx);
    chk(32'(four_lane_mode), 32'h0);
    sflm_host_inst.frame(CMD_ENTER_FOUR_LANE, 8, 1'b0, 0, 8'h00, rx);
    chk(32'(four_lane_mode), 32'h1);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h3f);
    $display("test 3 done");
    // exit in four-lane form, two clock rises for the code
    sflm_host_inst.frame(CMD_EXIT_FOUR_LANE, 2, 1'b1, 0, 8'h00, rx);
    chk(32'(four_lane_mode), 32'h0);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rd, 32'h3e);
    sflm_host_inst.frame(CMD_READ_PARAM, 8, 1'b0, 2, 8'h01, rx);
    chk(32'(rx), 32'h01);
    $display("test 4 done");
    final_report();
  end
endmodule
